/* src/cdcr_pkg.sv */
package cdcr_pkg;

	// Register byte addresses
	localparam logic [31:0] CH2_CODE_OFS = 32'h4008_6810;
	localparam logic [31:0] CH2_CTRL_OFS = 32'h4008_6814;
	localparam logic [31:0] CH3_CODE_OFS = 32'h4008_6818;
	localparam logic [31:0] CH3_CTRL_OFS = 32'h4008_681c;

	// Per local channel, index 0 is channel 2
	localparam logic [1:0][31:0] CODE_OFS = {CH3_CODE_OFS, CH2_CODE_OFS};
	localparam logic [1:0][31:0] CTRL_OFS = {CH3_CTRL_OFS, CH2_CTRL_OFS};

	// Data and control register field layout
	localparam int NUM_HOLD       = 4;
	localparam int HOLD_LSB       = 0;
	localparam int CODE_LOWER_LSB = 12;
	localparam int CODE_LOWER_W   = 5;
	localparam int CODE_UPPER_LSB = 17;
	localparam int CODE_UPPER_W   = 11;
	localparam int CTRL_W         = 8;
	localparam int BW_W           = 4;

	// Writable bits of a data register; reserved bits stay zero
	localparam logic [31:0] DATA_WR_MASK = 32'h0fff_f00f;

	// Reset values
	localparam logic [31:0]       DATA_RESET = 32'h0000_0000;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h01;

	// Control register layout, bit 7 down to bit 0
	typedef struct packed {
		logic            write_allow_clear;
		logic            overtemp_shutdown_enable;
		logic [BW_W-1:0] bandwidth_select;
		logic            sink_current_enable;
		logic            power_off;
	} cdcr_ctrl_t;

	// Output code as applied to the converter
	typedef struct packed {
		logic [CODE_UPPER_W-1:0] code_upper;
		logic [CODE_LOWER_W-1:0] code_lower;
	} cdcr_code_t;

endpackage : cdcr_pkg

/* src/cdcr_pin_sync.sv */
module cdcr_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         i_ref_clk,  // System clock
	input  wire logic         i_reset_n,  // Synchronous reset, active low
	input  wire logic [W-1:0] i_pin,      // Asynchronous pin level
	output logic      [W-1:0] o_level     // Filtered level
);

	logic [W-1:0] hold_update_ch1_ff;
	logic [W-1:0] hold_update_ch2_ff;
	logic [W-1:0] hold_update_ch3_ff;
	logic [W-1:0] level_ff;

	// Three-stage chain; only the second stage reads the first
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			hold_update_ch1_ff <= '0;
			hold_update_ch2_ff <= '0;
			hold_update_ch3_ff <= '0;
		end else begin
			hold_update_ch1_ff <= i_pin;
			hold_update_ch2_ff <= hold_update_ch1_ff;
			hold_update_ch3_ff <= hold_update_ch2_ff;
		end
	end

	// A change counts only once stages two and three agree
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			level_ff <= '0;
		end else begin
			for (int b = 0; b < W; b++) begin
				if (hold_update_ch2_ff[b] == hold_update_ch3_ff[b]) begin
					level_ff[b] <= hold_update_ch3_ff[b];
				end
			end
		end
	end

	assign o_level = level_ff;

endmodule : cdcr_pin_sync

/* src/cdcr_code_stage.sv */
module cdcr_code_stage (
	input  wire logic                 i_ref_clk,  // System clock
	input  wire logic                 i_reset_n,  // Synchronous reset, active low
	input  cdcr_pkg::cdcr_code_t      i_code,     // Code held in the data register
	input  wire logic                 i_hold,     // All hold bits of this channel set
	output cdcr_pkg::cdcr_code_t      o_code      // Code driving the converter
);

	cdcr_pkg::cdcr_code_t code_ff;

	// Follows the register unless every hold bit for this channel is set
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			code_ff <= '0;
		end else if (!i_hold) begin
			code_ff <= i_code;
		end
	end

	assign o_code = code_ff;

endmodule : cdcr_code_stage

/* src/cdcr_channel_regs.sv */
// Contract
// - Channel output stays frozen while its hold bit is set in all four data registers.
// - Any data register with that hold bit clear lets written codes apply at once.
// - Every data register carries all four readable, writable hold bits at 3:0.
// - Shutdown enable bit 6 powers the channel off on overtemperature; 0 disables.
// - Control bit 1 switches the pull-down current source on or off.
// - Four-bit bandwidth field at bits 5:2, read/write, resets to zero.
//
// Added by the designer: the plain strobed port.
module cdcr_channel_regs #(
	parameter int NCH      = 2,  // Channels in this bank
	parameter int FIRST_CH = 2   // Global number of local channel 0
) (
	input  wire logic                             i_ref_clk,       // 20 MHz clock
	input  wire logic                             i_reset_n,       // Sync reset, active low
	input  wire logic [31:0]                      i_addr,          // Register byte address
	input  wire logic [31:0]                      i_wdata,         // Write data
	input  wire logic                             i_wr,            // Write strobe
	input  wire logic                             i_rd,            // Read strobe
	output logic      [31:0]                      o_rdata,         // Read data, cycle after
	input  wire logic [cdcr_pkg::NUM_HOLD-1:0]    i_hold_ch0,      // Hold bits, channel 0 reg
	input  wire logic [cdcr_pkg::NUM_HOLD-1:0]    i_hold_ch1,      // Hold bits, channel 1 reg
	output logic [NCH-1:0][cdcr_pkg::NUM_HOLD-1:0] o_hold_regs,    // Hold bits of this bank
	input  wire logic                             i_overtemp,      // Overtemperature pin
	output cdcr_pkg::cdcr_code_t [NCH-1:0]        o_code,          // Applied codes
	output logic [NCH-1:0]                        o_power_off,     // Channel powered down
	output logic [NCH-1:0]                        o_shutdown,      // Thermal shutdown active
	output logic [NCH-1:0]                        o_sink_enable,   // Pull-down source on
	output logic [NCH-1:0][cdcr_pkg::BW_W-1:0]    o_bandwidth      // Filter bandwidth
);

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_reset_n);

	logic [NCH-1:0][31:0]               data_ff;
	cdcr_pkg::cdcr_ctrl_t [NCH-1:0]     ctrl_ff;
	logic [NCH-1:0]                     hit_code;
	logic [NCH-1:0]                     hit_ctrl;
	logic [cdcr_pkg::NUM_HOLD-1:0]      all_hold;
	logic [NCH-1:0]                     held;
	cdcr_pkg::cdcr_code_t [NCH-1:0]     code_word;
	logic [31:0]                        nxt_rdata;
	logic [31:0]                        rdata_ff;
	logic                               ot_level;
	logic [NCH-1:0]                     power_off_ff;
	logic [NCH-1:0]                     shutdown_ff;
	logic [NCH-1:0]                     sink_ff;
	logic [NCH-1:0][cdcr_pkg::BW_W-1:0] bw_ff;

	// Address decode; only exact word addresses hit
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			hit_code[c] = (i_addr == cdcr_pkg::CODE_OFS[c]);
			hit_ctrl[c] = (i_addr == cdcr_pkg::CTRL_OFS[c]);
		end
	end

	// A channel is held only if its bit is set in every channel's register
	always_comb begin
		for (int n = 0; n < cdcr_pkg::NUM_HOLD; n++) begin
			all_hold[n] = i_hold_ch0[n] & i_hold_ch1[n];
			for (int c = 0; c < NCH; c++) begin
				all_hold[n] = all_hold[n] & data_ff[c][cdcr_pkg::HOLD_LSB + n];
			end
		end
	end

	// Overtemperature arrives from the analogue side, so it is filtered first
	cdcr_pin_sync #(
		.W (1)
	) u_ot_sync (
		.i_ref_clk (i_ref_clk),
		.i_reset_n (i_reset_n),
		.i_pin     (i_overtemp),
		.o_level   (ot_level)
	);

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_ch

			// Clear dominates writes, so software cannot load a locked register
			always_ff @(posedge i_ref_clk) begin
				if (!i_reset_n) begin
					data_ff[c] <= cdcr_pkg::DATA_RESET;
				end else if (!ctrl_ff[c].write_allow_clear) begin
					data_ff[c] <= cdcr_pkg::DATA_RESET;
				end else if (i_wr && hit_code[c]) begin
					data_ff[c] <= i_wdata & cdcr_pkg::DATA_WR_MASK;
				end
			end

			// Control register, plain read/write
			always_ff @(posedge i_ref_clk) begin
				if (!i_reset_n) begin
					ctrl_ff[c] <= cdcr_pkg::cdcr_ctrl_t'(cdcr_pkg::CTRL_RESET);
				end else if (i_wr && hit_ctrl[c]) begin
					ctrl_ff[c] <= cdcr_pkg::cdcr_ctrl_t'(i_wdata[cdcr_pkg::CTRL_W-1:0]);
				end
			end

			// Code fields pulled out of the data register
			assign code_word[c].code_upper =
				data_ff[c][cdcr_pkg::CODE_UPPER_LSB +: cdcr_pkg::CODE_UPPER_W];
			assign code_word[c].code_lower =
				data_ff[c][cdcr_pkg::CODE_LOWER_LSB +: cdcr_pkg::CODE_LOWER_W];
			assign held[c] = all_hold[FIRST_CH + c];

			// Applied code; held writes land once this channel's hold bit drops in any register
			cdcr_code_stage u_stage (
				.i_ref_clk (i_ref_clk),
				.i_reset_n (i_reset_n),
				.i_code    (code_word[c]),
				.i_hold    (held[c]),
				.o_code    (o_code[c])
			);

			// Analogue controls, registered so outputs come from flops
			always_ff @(posedge i_ref_clk) begin
				if (!i_reset_n) begin
					power_off_ff[c] <= 1'b1;
					shutdown_ff[c]  <= 1'b0;
					sink_ff[c]      <= 1'b0;
					bw_ff[c]        <= '0;
				end else begin
					shutdown_ff[c]  <= ctrl_ff[c].overtemp_shutdown_enable & ot_level;
					power_off_ff[c] <= ctrl_ff[c].power_off |
						(ctrl_ff[c].overtemp_shutdown_enable & ot_level);
					sink_ff[c]      <= ctrl_ff[c].sink_current_enable;
					bw_ff[c]        <= ctrl_ff[c].bandwidth_select;
				end
			end

			// Write to this channel's control register, left alone next cycle
			sequence seq_ctrl_wr;
				(i_wr && hit_ctrl[c]) ##1 !(i_wr && hit_ctrl[c]);
			endsequence

			// Control write followed at once by its read-back
			sequence seq_ctrl_rb;
				(i_wr && hit_ctrl[c]) ##1 (i_rd && hit_ctrl[c]);
			endsequence

			// Code write with writes allowed, then read-back
			sequence seq_code_rb;
				(i_wr && hit_code[c] && ctrl_ff[c].write_allow_clear)
				##1 (i_rd && hit_code[c] && ctrl_ff[c].write_allow_clear);
			endsequence

			AST_HOLD_FREEZE: assert property (
				held[c] |=> $stable(o_code[c])
			) else $error("held channel output changed");

			AST_APPLY_NOW: assert property (
				!held[c] |=> (o_code[c] == $past(code_word[c]))
			) else $error("unheld channel did not take the register code");

			AST_WRITE_APPLIES: assert property (
				(i_wr && hit_code[c] && ctrl_ff[c].write_allow_clear) ##1 !held[c]
				|=> (o_code[c].code_upper == $past(i_wdata[27:17], 2))
			) else $error("written code not applied two cycles later");

			AST_HOLD_READBACK: assert property (
				seq_code_rb |=> (o_rdata[3:0] == $past(i_wdata[3:0], 2))
				&& (o_rdata[11:4] == 8'h00) && (o_rdata[31:28] == 4'h0)
			) else $error("hold bits did not read back");

			AST_OT_SHUTDOWN: assert property (
				(ctrl_ff[c].overtemp_shutdown_enable && ot_level)
				|=> (o_power_off[c] && o_shutdown[c])
			) else $error("overtemperature did not shut channel down");

			AST_OT_DISABLED: assert property (
				!ctrl_ff[c].overtemp_shutdown_enable |=> !o_shutdown[c]
			) else $error("shutdown asserted while disabled");

			AST_SINK_FOLLOWS: assert property (
				seq_ctrl_wr |=> (o_sink_enable[c] == $past(i_wdata[1], 2))
			) else $error("pull-down output does not follow control write");

			AST_BW_READBACK: assert property (
				seq_ctrl_rb |=> (o_rdata[5:2] == $past(i_wdata[5:2], 2))
				&& (o_bandwidth[c] == $past(i_wdata[5:2], 2))
			) else $error("bandwidth field mismatch");

			AST_CLEAR_LOCK: assert property (
				!ctrl_ff[c].write_allow_clear |=> (data_ff[c] == 32'h0000_0000)
			) else $error("data register not cleared while clear bit low");

			AST_POWER_OFF: assert property (
				ctrl_ff[c].power_off |=> o_power_off[c]
			) else $error("power-down bit did not power channel off");

			// Code register write lands next cycle with reserved bits dropped
			AST_DATA_WRITE: assert property (
				(i_wr && hit_code[c] && ctrl_ff[c].write_allow_clear)
				|=> (data_ff[c] == ($past(i_wdata) & cdcr_pkg::DATA_WR_MASK))
			) else $error("data register did not take the write");

			// Locked register ignores software writes
			AST_WRITE_BLOCKED: assert property (
				(i_wr && hit_code[c] && !ctrl_ff[c].write_allow_clear)
				|=> (data_ff[c] == cdcr_pkg::DATA_RESET)
			) else $error("write landed in a locked data register");

			// Control register takes the low byte of a write
			AST_CTRL_WRITE: assert property (
				(i_wr && hit_ctrl[c])
				|=> (ctrl_ff[c] == $past(i_wdata[cdcr_pkg::CTRL_W-1:0]))
			) else $error("control register did not take the write");

			// Bandwidth output trails the register by one cycle
			AST_BW_FOLLOWS: assert property (
				1'b1 |=> (o_bandwidth[c] == $past(ctrl_ff[c].bandwidth_select))
			) else $error("bandwidth output does not follow the register");

			// Pull-down output trails the register both ways, on and off
			AST_SINK_TRACKS: assert property (
				1'b1 |=> (o_sink_enable[c] == $past(ctrl_ff[c].sink_current_enable))
			) else $error("pull-down output does not follow the register");

			// Power-down clear and no thermal trip, so the channel must run
			AST_POWER_ON: assert property (
				(!ctrl_ff[c].power_off &&
					!(ctrl_ff[c].overtemp_shutdown_enable && ot_level))
				|=> !o_power_off[c]
			) else $error("channel stayed powered down");

			// No overtemperature, no shutdown, whatever the enable
			AST_OT_LEVEL: assert property (
				!ot_level |=> !o_shutdown[c]
			) else $error("shutdown asserted without overtemperature");

			// Data register read returns the stored word
			AST_RD_CODE: assert property (
				(i_rd && hit_code[c]) |=> (o_rdata == $past(data_ff[c]))
			) else $error("data register read-back mismatch");

			// Control register read returns the byte, upper bits zero
			AST_RD_CTRL: assert property (
				(i_rd && hit_ctrl[c]) |=> (o_rdata == 32'($past(ctrl_ff[c])))
			) else $error("control register read-back mismatch");

			// Reserved data bits can never hold a one
			AST_RSVD_ZERO: assert property (
				(data_ff[c] & ~cdcr_pkg::DATA_WR_MASK) == 32'h0000_0000
			) else $error("reserved data bit set");

			// Channel held for a cycle, then released
			sequence seq_hold_release;
				held[c] ##1 !held[c];
			endsequence

			AST_RELEASE_APPLIES: assert property (
				seq_hold_release |=> (o_code[c] == $past(code_word[c]))
			) else $error("pending code not applied on release");

			// Held in two cycles in a row
			sequence seq_held_twice;
				held[c] ##1 held[c];
			endsequence

			AST_HOLD_TWICE: assert property (
				seq_held_twice |=> (o_code[c] == $past(o_code[c], 2))
			) else $error("held output drifted across two cycles");

		end
	endgenerate

	// Read mux; reserved bits and unmapped addresses read as zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		for (int k = 0; k < NCH; k++) begin
			if (hit_code[k]) begin
				nxt_rdata = data_ff[k];
			end
			if (hit_ctrl[k]) begin
				nxt_rdata = 32'(ctrl_ff[k]);
			end
		end
	end

	// Read data stands only in the cycle after the strobe, zero otherwise
	always_ff @(posedge i_ref_clk) begin
		if (!i_reset_n) begin
			rdata_ff <= 32'h0000_0000;
		end else if (i_rd) begin
			rdata_ff <= nxt_rdata;
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	AST_RDATA_IDLE: assert property (
		!i_rd |=> (o_rdata == 32'h0000_0000)
	) else $error("read data not zero outside a read");

	// Unmapped reads return zero
	AST_RD_UNMAPPED: assert property (
		(i_rd && !(|hit_code) && !(|hit_ctrl)) |=> (o_rdata == 32'h0000_0000)
	) else $error("unmapped read returned data");

	// Output ports taken straight from the flops
	assign o_rdata       = rdata_ff;
	assign o_power_off   = power_off_ff;
	assign o_shutdown    = shutdown_ff;
	assign o_sink_enable = sink_ff;
	assign o_bandwidth   = bw_ff;

	// Hold bits of this bank go to the channel 0/1 bank, which needs them too
	always_comb begin
		for (int k = 0; k < NCH; k++) begin
			o_hold_regs[k] = data_ff[k][cdcr_pkg::HOLD_LSB +: cdcr_pkg::NUM_HOLD];
		end
	end

endmodule : cdcr_channel_regs

/* sim/tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	logic                       i_ref_clk;
	logic                       i_reset_n;
	logic                       i_wr;
	logic                       i_rd;
	logic                       i_overtemp;
	logic [31:0]                i_addr;
	logic [31:0]                i_wdata;
	logic [3:0]                 i_hold_ch0;
	logic [3:0]                 i_hold_ch1;
	logic [31:0]                o_rdata;
	logic [1:0][3:0]            o_hold_regs;
	logic [1:0][3:0]            o_bandwidth;
	cdcr_pkg::cdcr_code_t [1:0] o_code;
	logic [1:0]                 o_power_off;
	logic [1:0]                 o_shutdown;
	logic [1:0]                 o_sink_enable;
	int                         failures;
	int                         num_checks;

	cdcr_channel_regs #(.NCH(2), .FIRST_CH(2)) uut (
		.i_ref_clk     (i_ref_clk),
		.i_reset_n     (i_reset_n),
		.i_addr        (i_addr),
		.i_wdata       (i_wdata),
		.i_wr          (i_wr),
		.i_rd          (i_rd),
		.o_rdata       (o_rdata),
		.i_hold_ch0    (i_hold_ch0),
		.i_hold_ch1    (i_hold_ch1),
		.o_hold_regs   (o_hold_regs),
		.i_overtemp    (i_overtemp),
		.o_code        (o_code),
		.o_power_off   (o_power_off),
		.o_shutdown    (o_shutdown),
		.o_sink_enable (o_sink_enable),
		.o_bandwidth   (o_bandwidth)
	);

	// 20 MHz clock
	initial begin
		i_ref_clk = 1'b0;
		forever #25 i_ref_clk = ~i_ref_clk;
	end

	// Single verdict point, also reached by the watchdog
	task automatic wrap_up();
		if (failures == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up

	// Four-state compare of any port value
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_val

	// One-cycle write strobe
	task automatic wr(input logic [31:0] addr, input logic [31:0] data);
		@(posedge i_ref_clk);
		i_wr    <= 1'b1;
		i_addr  <= addr;
		i_wdata <= data;
		@(posedge i_ref_clk);
		i_wr    <= 1'b0;
	endtask : wr

	// Read data only stands in the cycle after the strobe
	task automatic rd_chk(input logic [31:0] addr, input logic [31:0] exp);
		@(posedge i_ref_clk);
		i_rd   <= 1'b1;
		i_addr <= addr;
		@(posedge i_ref_clk);
		i_rd   <= 1'b0;
		#1;
		chk_val(o_rdata, exp);
	endtask : rd_chk

	// Write then read the same register in back-to-back cycles
	task automatic wr_rd_chk(input logic [31:0] addr, input logic [31:0] data,
			input logic [31:0] exp);
		@(posedge i_ref_clk);
		i_wr    <= 1'b1;
		i_addr  <= addr;
		i_wdata <= data;
		@(posedge i_ref_clk);
		i_wr    <= 1'b0;
		i_rd    <= 1'b1;
		@(posedge i_ref_clk);
		i_rd    <= 1'b0;
		#1;
		chk_val(o_rdata, exp);
	endtask : wr_rd_chk

	// Let registered outputs land before looking
	task automatic settle(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask : settle

	// Filter latency is only approximate, so poll under a bound
	task automatic wait_shut(input logic [1:0] exp);
		int n;
		n = 0;
		while (o_shutdown !== exp && n < 12) begin
			settle(1);
			n++;
		end
		chk_val(32'(o_shutdown), 32'(exp));
	endtask : wait_shut

	// Watchdog sized well above the whole sequence
	initial begin
		#200000;
		failures++;
		wrap_up();
	end

	// Main sequence
	initial begin
		failures   = 0;
		num_checks = 0;
		i_reset_n  = 1'b0;
		i_wr       = 1'b0;
		i_rd       = 1'b0;
		i_overtemp = 1'b0;
		i_addr     = 32'h0;
		i_wdata    = 32'h0;
		i_hold_ch0 = 4'h0;
		i_hold_ch1 = 4'h0;
		repeat (20) @(posedge i_ref_clk);
		i_reset_n <= 1'b1;
		rd_chk(cdcr_pkg::CH2_CTRL_OFS, 32'h01);
		rd_chk(cdcr_pkg::CH3_CTRL_OFS, 32'h01);
		rd_chk(cdcr_pkg::CH2_CODE_OFS, 32'h0);
		chk_val(32'(o_power_off), 32'h3);
		chk_val(32'(o_bandwidth), 32'h0);
		// Every control field but shutdown enable and power-off set at once, upper bits ignored
		wr(cdcr_pkg::CH2_CTRL_OFS, 32'hffff_ffbe);
		settle(2);
		rd_chk(cdcr_pkg::CH2_CTRL_OFS, 32'hbe);
		chk_val(32'(o_bandwidth[0]), 32'hf);
		chk_val(32'(o_sink_enable), 32'h1);
		chk_val(32'(o_power_off), 32'h2);
		// Back-to-back write and read-back of a control register
		wr_rd_chk(cdcr_pkg::CH3_CTRL_OFS, 32'h0000_00a9, 32'ha9);
		chk_val(32'(o_bandwidth[1]), 32'ha);
		wr(cdcr_pkg::CH3_CTRL_OFS, 32'h80);
		// Reserved data bits read back as zero, read right after the write
		wr_rd_chk(cdcr_pkg::CH2_CODE_OFS, 32'hffff_ffff, 32'h0fff_f00f);
		settle(1);
		chk_val(32'(o_hold_regs[0]), 32'hf);
		chk_val(32'(o_code[0]), 32'hffff);
		// All four hold bits of channel 2 set: output frozen
		@(posedge i_ref_clk);
		i_hold_ch0 <= 4'hf;
		i_hold_ch1 <= 4'hf;
		wr(cdcr_pkg::CH3_CODE_OFS, 32'h0000_0004);
		wr(cdcr_pkg::CH2_CODE_OFS, 32'h0123_400f);
		settle(3);
		rd_chk(cdcr_pkg::CH3_CODE_OFS, 32'h4);
		chk_val(32'(o_code[0]), 32'hffff);
		// One clear hold bit elsewhere releases the pending code
		@(posedge i_ref_clk);
		i_hold_ch1 <= 4'hb;
		settle(3);
		chk_val(32'(o_code[0]), 32'h1234);
		// Channel 3 held by its bit 3 in all four registers
		wr(cdcr_pkg::CH3_CODE_OFS, 32'h0abc_d008);
		settle(3);
		chk_val(32'(o_code[1]), 32'h0);
		chk_val(32'(o_hold_regs[1]), 32'h8);
		wr(cdcr_pkg::CH2_CODE_OFS, 32'h0123_4007);
		settle(3);
		chk_val(32'(o_code[1]), 32'habcd);
		chk_val(32'(o_hold_regs[0]), 32'h7);
		// Clear bit low wipes and locks the data register
		wr(cdcr_pkg::CH2_CTRL_OFS, 32'h00);
		settle(2);
		chk_val(32'(o_sink_enable), 32'h0);
		rd_chk(cdcr_pkg::CH2_CODE_OFS, 32'h0);
		wr(cdcr_pkg::CH2_CODE_OFS, 32'hffff_ffff);
		settle(1);
		rd_chk(cdcr_pkg::CH2_CODE_OFS, 32'h0);
		// Shutdown only where enabled
		wr(cdcr_pkg::CH3_CTRL_OFS, 32'hc0);
		settle(2);
		chk_val(32'(o_power_off[1]), 32'h0);
		@(posedge i_ref_clk);
		i_overtemp <= 1'b1;
		wait_shut(2'b10);
		chk_val(32'(o_power_off[1]), 32'h1);
		wr(cdcr_pkg::CH3_CTRL_OFS, 32'h80);
		settle(2);
		chk_val(32'(o_shutdown), 32'h0);
		chk_val(32'(o_power_off[1]), 32'h0);
		@(posedge i_ref_clk);
		i_overtemp <= 1'b0;
		// Unmapped address reads zero
		rd_chk(32'h4008_6820, 32'h0);
		rd_chk(cdcr_pkg::CH3_CTRL_OFS, 32'h80);
		wrap_up();
	end

endmodule : tb_top
